// ==== rtl/nvc_pkg.sv ====
//==================================================================
// Overview of operation
// - bit 11 reads one while controller busy
// - operation runs only when arm bit set
// - eight-bit counter counts executed write cycles
// - read-only 16-bit slices of array contents
`default_nettype none
package nvc_pkg;
    //==================================================================
    // register indices, byte address is four times the index
    localparam logic [9:0] NVC_IDX_SLICE80 = 10'h059; // read slice 80..95
    localparam logic [9:0] NVC_IDX_SLICE96 = 10'h05A; // read slice 96..111
    localparam logic [9:0] NVC_IDX_CMD = 10'h05B; // command and control
    localparam logic [9:0] NVC_IDX_UNLOCK = 10'h05C; // write-only unlock
    localparam logic [9:0] NVC_IDX_WDATA = 10'h060; // program data word
    localparam logic [9:0] NVC_IDX_WADDR = 10'h061; // program slice index
    localparam int NVC_ADDR_W = 12;
    //==================================================================
    // field layout of the command register
    localparam int NVC_BUSY_BIT = 11;
    localparam int NVC_OP_LSB = 9;
    localparam int NVC_ARM_BIT = 8;
    localparam int NVC_CNT_W = 8;
    localparam logic [1:0] NVC_OP_ERASE = 2'h2;
    localparam logic [1:0] NVC_OP_WRITE = 2'h3;
    localparam int NVC_REG_W = 18;
    localparam int NVC_SLICE_W = 16;
    localparam int NVC_SLICES = 7;
    localparam int NVC_SADDR_W = 3;
    localparam logic [NVC_REG_W-1:0] NVC_RESET_VAL = 18'h00000;
    localparam logic [NVC_SLICE_W-1:0] NVC_ERASED = 16'h0000;
    // unlock key, value is arbitrary
    localparam logic [NVC_REG_W-1:0] NVC_UNLOCK_KEY = 18'h2A5C3;
    //==================================================================
    // timing
    localparam int NVC_CLK_MHZ = 25;
    localparam int NVC_ERASE_US = 20;
    localparam int NVC_WRITE_US = 10;
    localparam int NVC_ERASE_CYC = NVC_ERASE_US * NVC_CLK_MHZ;
    localparam int NVC_WRITE_CYC = NVC_WRITE_US * NVC_CLK_MHZ;
    localparam int NVC_TMR_W = 10;
endpackage
`default_nettype wire

// ==== rtl/nvc_array_if.sv ====
`timescale 1ns/1ps
`default_nettype none
//==================================================================
// link between register front end and array engine
interface nvc_array_if;
    import nvc_pkg::*;
    logic start; // one-cycle launch
    logic opErase; // erase when high, write when low
    logic [NVC_SADDR_W-1:0] wrAddr; // slice to program
    logic [NVC_SLICE_W-1:0] wrData; // word to program
    logic busy; // operation in progress
    logic done; // one-cycle end of operation
    logic [NVC_SLICE_W-1:0] slice80; // array bits 80..95
    logic [NVC_SLICE_W-1:0] slice96; // array bits 96..111
    modport ctrl (output start, opErase, wrAddr, wrData, input busy, done, slice80, slice96);
    modport eng (input start, opErase, wrAddr, wrData, output busy, done, slice80, slice96);
endinterface
`default_nettype wire

// ==== rtl/nvc_array_engine.sv ====
`timescale 1ns/1ps
`default_nettype none
//==================================================================
// array model with timed erase and write
module nvc_array_engine
    import nvc_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // command side
    nvc_array_if.eng arr
);
    typedef enum logic {NVC_IDLE, NVC_RUN} nvc_st_e;
    typedef struct packed {
        nvc_st_e st; // engine phase
        logic erase; // operation being run
        logic [NVC_SADDR_W-1:0] addr; // target slice
        logic [NVC_SLICE_W-1:0] data; // word being programmed
        logic [NVC_TMR_W-1:0] tmr; // cycles left
        logic done; // end pulse
        logic [NVC_SLICES-1:0][NVC_SLICE_W-1:0] mem; // cell contents
    } nvc_eng_s;
    nvc_eng_s state_reg;
    nvc_eng_s state_next;

    //==================================================================
    // next state
    always_comb begin
        state_next = state_reg;
        state_next.done = 1'b0;
        case (state_reg.st)
            NVC_IDLE: begin
                if (arr.start) begin
                    state_next.st = NVC_RUN;
                    state_next.erase = arr.opErase;
                    state_next.addr = arr.wrAddr;
                    state_next.data = arr.wrData;
                    // erase is the slower cycle on the cells
                    state_next.tmr = arr.opErase ? NVC_TMR_W'(NVC_ERASE_CYC - 1) : NVC_TMR_W'(NVC_WRITE_CYC - 1);
                end
            end
            NVC_RUN: begin
                if (state_reg.tmr == '0) begin
                    // contents change only at the end of the cycle
                    state_next.st = NVC_IDLE;
                    state_next.done = 1'b1;
                    if (state_reg.erase) begin
                        for (int i = 0; i < NVC_SLICES; i++) begin
                            state_next.mem[i] = NVC_ERASED;
                        end
                    end else if (state_reg.addr < NVC_SADDR_W'(NVC_SLICES)) begin
                        state_next.mem[state_reg.addr] = state_reg.data;
                    end
                end else begin
                    state_next.tmr = state_reg.tmr - 1'b1;
                end
            end
            default: begin
                state_next.st = NVC_IDLE;
            end
        endcase
    end

    //==================================================================
    // state register
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign arr.busy = (state_reg.st == NVC_RUN);
    assign arr.done = state_reg.done;
    assign arr.slice80 = state_reg.mem[5];
    assign arr.slice96 = state_reg.mem[6];
endmodule // nvc_array_engine
`default_nettype wire

// ==== rtl/nvc_command_control.sv ====
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
//==================================================================
// non-volatile array command control, APB slave
module nvc_command_control
    import nvc_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [NVC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    typedef struct packed {
        logic [1:0] opSel; // array_op_select
        logic arm; // array_op_arm
        logic unlocked; // key accepted
        logic [NVC_CNT_W-1:0] count; // write_cycle_count
        logic [NVC_SLICE_W-1:0] wData; // word to program
        logic [NVC_SADDR_W-1:0] wAddr; // slice to program
        logic start; // launch pulse to engine
        logic startErase; // operation of the launch
        logic runWrite; // running op is a write
        logic [31:0] rdata; // read data held for access phase
    } nvc_top_s;
    nvc_top_s state_reg;
    nvc_top_s state_next;

    nvc_array_if arr ();

    nvc_array_engine u_engine (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .arr(arr)
    );

    //==================================================================
    // address decode
    logic [9:0] regIdx; // word index of the access
    logic mapped; // address hits a register
    logic setup; // apb setup phase
    logic access; // apb access phase
    logic wrCmd; // write taking effect on command register
    logic [NVC_REG_W-1:0] cmdView; // command register as read
    logic [31:0] rdMux; // read value for the decoded register

    assign regIdx = paddr[NVC_ADDR_W-1:2];
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign wrCmd = access & pwrite & (regIdx == NVC_IDX_CMD);

    // command register view, bits above 11 read zero
    always_comb begin
        cmdView = NVC_RESET_VAL;
        cmdView[NVC_BUSY_BIT] = arr.busy;
        cmdView[NVC_OP_LSB +: 2] = state_reg.opSel;
        cmdView[NVC_ARM_BIT] = state_reg.arm;
        cmdView[NVC_CNT_W-1:0] = state_reg.count;
    end

    // read mux, unlock and unmapped words read zero
    always_comb begin
        rdMux = 32'h00000000;
        mapped = 1'b1;
        case (regIdx)
            NVC_IDX_SLICE80: rdMux = {16'h0000, arr.slice80};
            NVC_IDX_SLICE96: rdMux = {16'h0000, arr.slice96};
            NVC_IDX_CMD: rdMux = {14'h0000, cmdView};
            NVC_IDX_UNLOCK: rdMux = 32'h00000000;
            NVC_IDX_WDATA: rdMux = {16'h0000, state_reg.wData};
            NVC_IDX_WADDR: rdMux = {29'h00000000, state_reg.wAddr};
            default: mapped = 1'b0;
        endcase
    end

    //==================================================================
    // next state
    always_comb begin
        state_next = state_reg;
        state_next.start = 1'b0;
        // capture read data in setup so prdata comes from a flop
        if (setup && !pwrite) begin
            state_next.rdata = rdMux;
        end
        // end of operation disarms, a new arm is needed for the next one;
        // done comes while busy is already low, so it is handled before the
        // command write below, letting a launch in the same cycle win
        if (arr.done) begin
            state_next.arm = 1'b0;
            if (state_reg.runWrite) begin
                state_next.count = state_reg.count + 1'b1;
            end
        end
        // fields cannot change under a running operation
        if (wrCmd && !arr.busy && !state_reg.start) begin
            state_next.opSel = pwdata[NVC_OP_LSB +: 2];
            state_next.arm = pwdata[NVC_ARM_BIT];
            // launch only armed, unlocked, erase or write codes
            if (pwdata[NVC_ARM_BIT] && pwdata[NVC_OP_LSB + 1] && state_reg.unlocked) begin
                state_next.start = 1'b1;
                state_next.startErase = (pwdata[NVC_OP_LSB +: 2] == NVC_OP_ERASE);
                state_next.runWrite = (pwdata[NVC_OP_LSB +: 2] == NVC_OP_WRITE);
                // key is single use, each operation needs a fresh unlock
                state_next.unlocked = 1'b0;
            end
        end
        if (access && pwrite && regIdx == NVC_IDX_UNLOCK) begin
            state_next.unlocked = (pwdata[NVC_REG_W-1:0] == NVC_UNLOCK_KEY);
        end
        if (access && pwrite && regIdx == NVC_IDX_WDATA && !arr.busy) begin
            state_next.wData = pwdata[NVC_SLICE_W-1:0];
        end
        if (access && pwrite && regIdx == NVC_IDX_WADDR && !arr.busy) begin
            state_next.wAddr = pwdata[NVC_SADDR_W-1:0];
        end
    end

    //==================================================================
    // state register
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    //==================================================================
    // engine and bus outputs
    assign arr.start = state_reg.start;
    assign arr.opErase = state_reg.startErase;
    assign arr.wrAddr = state_reg.wAddr;
    assign arr.wrData = state_reg.wData;
    assign prdata = state_reg.rdata;
    assign pready = access; // zero wait states
    assign pslverr = access & ~mapped;
endmodule // nvc_command_control
`default_nettype wire

// ==== bench/nvc_command_control_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
//==================================================================
// apb port checker
module nvc_command_control_asserts
    import nvc_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // apb slave ports
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [NVC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    logic [9:0] idx; // word index
    logic mapped; // decoded place
    assign idx = paddr[11:2];
    assign mapped = idx inside {NVC_IDX_SLICE80, NVC_IDX_SLICE96, NVC_IDX_CMD, NVC_IDX_UNLOCK,
        NVC_IDX_WDATA, NVC_IDX_WADDR};
    // a setup cycle, and a read access to one place
    sequence setupPh;
        psel && !penable;
    endsequence
    sequence readAcc(logic [9:0] i);
        psel && penable && !pwrite && idx == i;
    endsequence
    // zero wait states: access follows setup and completes
    ready_zero_wait_a: assert property (setupPh ##1 (psel && penable) |-> pready) else $error("no ready");
    err_only_access_a: assert property (pslverr |-> psel && penable) else $error("stray error");
    unmapped_error_a: assert property (psel && penable && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped not refused");
    mapped_no_error_a: assert property (psel && penable && mapped |-> !pslverr) else $error("mapped refused");
    slice_width_a: assert property (readAcc(NVC_IDX_SLICE96) or readAcc(NVC_IDX_SLICE80) |->
        prdata[31:16] == 16'h0) else $error("slice upper bits");
    cmd_width_a: assert property (readAcc(NVC_IDX_CMD) |-> prdata[31:12] == 20'h0)
        else $error("cmd upper bits");
    busy_needs_arm_a: assert property (readAcc(NVC_IDX_CMD) and prdata[11] |-> prdata[8])
        else $error("busy unarmed");
    unlock_reads_zero_a: assert property (readAcc(NVC_IDX_UNLOCK) |-> prdata == 32'h0)
        else $error("unlock readable");
endmodule // nvc_command_control_asserts
bind nvc_command_control nvc_command_control_asserts i_chk (.clk_sys(clk_sys), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
//==================================================================
// self-checking bench, apb master
module tb_top
    import nvc_pkg::*;
;
    logic clk_sys = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdData, wd;
    logic pready, pslverr, rdErr, sawBusy;
    int checks = 0, n_mismatch = 0, cyc = 0;
    nvc_command_control i_dut (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    // hang guard, generous against the ~1100 cycles needed
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            test_done();
        end
    end
    function automatic logic [11:0] ba(logic [9:0] i);
        return {i, 2'b00};
    endfunction
    // expected command word from its fields
    function automatic logic [31:0] cmdExp(logic [1:0] op, logic arm, logic [7:0] cnt);
        return {21'h0, op, arm, cnt};
    endfunction
    // one transfer; request held until pready seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk_sys);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) n_mismatch++;
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // poll until the launched operation has come and gone
    task automatic waitIdle();
        int n = 0;
        sawBusy = 1'b0;
        do begin
            apb(1'b0, ba(NVC_IDX_CMD), 32'h0);
            sawBusy |= rdData[11];
            n++;
        end while (!(sawBusy && rdData[11] === 1'b0) && n < 600);
        chk({31'h0, sawBusy}, 32'h1);
    endtask
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        wd = $urandom(68);
        // reset values, then an unmapped place
        apb(1'b0, ba(NVC_IDX_SLICE80), 32'h0); chk(rdData, 32'h0);
        apb(1'b0, ba(NVC_IDX_SLICE96), 32'h0); chk(rdData, 32'h0);
        apb(1'b0, ba(NVC_IDX_CMD), 32'h0); chk(rdData, 32'h0);
        apb(1'b0, ba(NVC_IDX_UNLOCK), 32'h0); chk(rdData, 32'h0);
        apb(1'b0, ba(10'($urandom_range(32'h62, 32'h3FF))), 32'h0);
        chk({31'h0, rdErr}, 32'h1);
        $display("test reset done");
        // no-action codes armed: fields stored, read-only bits kept
        for (int op = 0; op < 2; op++) begin
            apb(1'b1, ba(NVC_IDX_CMD), ($urandom & 32'hFFFFF8FF) | {op[1:0], 9'h100});
            apb(1'b0, ba(NVC_IDX_CMD), 32'h0); chk(rdData, cmdExp(op[1:0], 1'b1, 8'h0));
        end
        // unlocked but unarmed write code stays idle
        apb(1'b1, ba(NVC_IDX_UNLOCK), 32'(NVC_UNLOCK_KEY));
        apb(1'b1, ba(NVC_IDX_CMD), 32'h600);
        apb(1'b0, ba(NVC_IDX_CMD), 32'h0); chk(rdData, cmdExp(2'h3, 1'b0, 8'h0));
        $display("test fields done");
        // two armed writes into the two visible slices
        for (int k = 0; k < 2; k++) begin
            wd = {16'h0, 16'($urandom)};
            apb(1'b1, ba(NVC_IDX_WDATA), wd);
            apb(1'b1, ba(NVC_IDX_WADDR), 32'(5 + k));
            apb(1'b1, ba(NVC_IDX_UNLOCK), 32'(NVC_UNLOCK_KEY));
            apb(1'b1, ba(NVC_IDX_CMD), 32'h700);
            waitIdle();
            chk(rdData, cmdExp(2'h3, 1'b0, 8'(k + 1)));
            apb(1'b0, ba(k ? NVC_IDX_SLICE96 : NVC_IDX_SLICE80), 32'h0); chk(rdData, wd);
        end
        // erase clears both slices and leaves the count alone
        apb(1'b1, ba(NVC_IDX_UNLOCK), 32'(NVC_UNLOCK_KEY));
        apb(1'b1, ba(NVC_IDX_CMD), 32'h500);
        waitIdle();
        chk(rdData, cmdExp(2'h2, 1'b0, 8'h2));
        apb(1'b0, ba(NVC_IDX_SLICE80), 32'h0); chk(rdData, 32'h0);
        apb(1'b0, ba(NVC_IDX_SLICE96), 32'h0); chk(rdData, 32'h0);
        $display("test operations done");
        test_done();
    end
endmodule // tb_top
`default_nettype wire
